//--- hdl/epsd_regs.svh
// Constants for the external-port slave and handshake DMA channel.
// Assumes inclusion by bare name from the design file.
`ifndef EPSD_REGS_SVH
`define EPSD_REGS_SVH
`define EPSD_FIFO_DEPTH 6
`define EPSD_WORD_WIDTH 32
`define EPSD_REQ_MAX 3'h7
`define EPSD_REQ_ZERO 3'h0
`define EPSD_REQ_ONE 3'h1
`define EPSD_BANK_IDLE 4'hf
`define EPSD_BANK_ACTIVE 4'he
`define EPSD_SYNC_STAGES 2
`endif

//--- hdl/epsd_pkg.sv
// Types for the external-port slave and handshake DMA channel.
// Assumes the constants header is available on the include path.
package epsd_pkg;
  typedef enum logic [1:0] {
    EPSD_MODE_SLAVE,
    EPSD_MODE_HANDSHAKE,
    EPSD_MODE_EXT_HANDSHAKE,
    EPSD_MODE_OTHER
  } epsd_mode_t;
  typedef enum logic [1:0] {
    EPSD_G_IDLE,
    EPSD_G_ARB,
    EPSD_G_GRANT,
    EPSD_G_RELEASE
  } epsd_gstate_t;
endpackage : epsd_pkg

//--- hdl/epsd_dma.sv
// External-port DMA channel: port FIFO, slave-mode fill and drain, access stall,
// request synchroniser, pending-request counter, grant sequencing and pipeline.
// Assumes one 100 MHz clock; the request pin is asynchronous, the external strobes arrive synchronous to it.
//
// Operation
// - With all mode bits clear, only outside reads or writes start transfers.
// - FIFO holds six words; outbound slave mode fills it until full.
// - Inbound slave mode issues no internal transfer while FIFO is empty.
// - Slave mode uses only internal index, modifier and count.
// - A complete word in FIFO raises an internal cycle request; grant moves it.
// - Write to full FIFO is stalled on ack or wait-ready until space.
// - Stalling applies only while buffer hang disable is zero.
// - Outbound requests start on enable, drop at full, resume after read.
// - Read of empty FIFO is stalled until internal transfers supply data.
// - Write ack drops only on full; reads after block end are stalled.
// - Request-grant bit with self-initiate clear enables grant handshake; here only while extern mode is also clear.
// - Pair one serves buffer one channel seven; pair two channel eight or six.
// - Bank selects idle in handshake; asserted in external handshake mode.
// - Request falling edge starts access, rising edge completes it.
// - Arbitrate for bus on request, never while FIFO is blocked.
// - Grant low after bus won, held until request seen high.
// - Short request pulse gives short grant and single bus cycle.
// - Three-stage pipeline: request, address and bus arbitration, transfer.
// - Count up to seven requests; grant only as often as counted.
// - More than seven outstanding is undefined; flush clears stored requests.
// - Blocked FIFO delays bus arbitration until DMA service unblocks it.
`timescale 1ns/10ps
`include "epsd_regs.svh"

module epsd_fifo #(
  parameter int WIDTH = `EPSD_WORD_WIDTH,
  parameter int DEPTH = `EPSD_FIFO_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic flush_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out,
  output logic full_out,
  output logic empty_out,
  output logic [$clog2(DEPTH+1)-1:0] level_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [CW-1:0] cnt_reg;
  logic push;
  logic pop;

  // Handshake terms; full and empty come straight from the word count.
  assign full_out = (cnt_reg == CW'(DEPTH));
  assign empty_out = (cnt_reg == '0);
  assign wr_ready_out = !full_out;
  assign rd_valid_out = !empty_out;
  assign push = wr_valid_in && !full_out;
  assign pop = rd_ready_in && !empty_out;
  assign level_out = cnt_reg;
  assign rd_data_out = mem_reg[rp_reg];

  // Storage array, written only on an accepted push.
  always_ff @(posedge ref_clk_in)
  begin
    if (push)
    begin
      mem_reg[wp_reg] <= wr_data_in;
    end
  end

  // Pointers and occupancy count.
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end
    else if (flush_in)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_reg <= (wp_reg == LAST) ? '0 : wp_reg + 1'b1;
      end
      if (pop)
      begin
        rp_reg <= (rp_reg == LAST) ? '0 : rp_reg + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_reg <= cnt_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule : epsd_fifo

module epsd_dma
  import epsd_pkg::*;
#(
  parameter int WIDTH = `EPSD_WORD_WIDTH,
  parameter int DEPTH = `EPSD_FIFO_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic chan_enable_in,
  input wire logic self_initiate_in,
  input wire logic req_grant_mode_bit_in,
  input wire logic extern_mode_in,
  input wire logic transmit_in,
  input wire logic buffer_hang_disable_in,
  input wire logic request_flush_bit_in,
  input wire logic bus_master_in,
  input wire logic bus_won_in,
  output logic bus_request_out,
  output logic int_dma_req_out,
  input wire logic int_dma_grant_in,
  input wire logic [WIDTH-1:0] int_rd_data_in,
  output logic [WIDTH-1:0] int_wr_data_out,
  output logic int_wr_strobe_out,
  input wire logic ext_wr_in,
  input wire logic ext_rd_in,
  input wire logic ext_sync_in,
  input wire logic [WIDTH-1:0] ext_wr_data_in,
  output logic [WIDTH-1:0] ext_rd_data_out,
  output logic ack_out,
  output logic host_wait_ready_out,
  input wire logic req_in_n,
  output logic grant_out_n,
  output logic grant_oe_out,
  output logic [3:0] bank_selects_out,
  output logic fifo_full_out,
  output logic fifo_empty_out,
  output logic [2:0] pending_count_out
);
  epsd_mode_t mode;
  epsd_gstate_t gstate_reg;
  logic [`EPSD_SYNC_STAGES-1:0] req_sync_reg;
  logic req_prev_reg;
  logic req_fall;
  logic [2:0] pend_reg;
  logic pipe_s1_reg;
  logic pipe_s2_reg;
  logic pipe_s3_reg;
  logic [WIDTH-1:0] ext_rd_data_reg;
  logic [WIDTH-1:0] int_wr_data_reg;
  logic int_wr_strobe_reg;
  logic f_wr_valid;
  logic f_wr_ready;
  logic f_rd_valid;
  logic f_rd_ready;
  logic [WIDTH-1:0] f_wr_data;
  logic [WIDTH-1:0] f_rd_data;
  logic f_full;
  logic f_empty;
  logic blocked;
  logic hs_active;
  logic stall;
  logic grant_fire;

  // Mode decode from the three mode bits.
  always_comb
  begin
    mode = EPSD_MODE_OTHER;
    if (!self_initiate_in && !req_grant_mode_bit_in && !extern_mode_in)
    begin
      mode = EPSD_MODE_SLAVE;
    end
    else if (!self_initiate_in && req_grant_mode_bit_in && !extern_mode_in)
    begin
      mode = EPSD_MODE_HANDSHAKE;
    end
    else if (!self_initiate_in && req_grant_mode_bit_in && extern_mode_in)
    begin
      mode = EPSD_MODE_EXT_HANDSHAKE;
    end
  end

  assign hs_active = chan_enable_in && (mode == EPSD_MODE_HANDSHAKE);

  // outbound fills from memory; inbound fills from outside writes.
  assign f_wr_valid = transmit_in ? (int_dma_grant_in && int_dma_req_out) :
                      (ext_wr_in || (hs_active && grant_fire));
  assign f_wr_data = transmit_in ? int_rd_data_in : ext_wr_data_in;
  assign f_rd_ready = transmit_in ? (ext_rd_in || (hs_active && grant_fire)) :
                      (int_dma_grant_in && int_dma_req_out);

  epsd_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_port_fifo (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .flush_in(!chan_enable_in),
    .wr_valid_in(f_wr_valid),
    .wr_ready_out(f_wr_ready),
    .wr_data_in(f_wr_data),
    .rd_valid_out(f_rd_valid),
    .rd_ready_in(f_rd_ready),
    .rd_data_out(f_rd_data),
    .full_out(f_full),
    .empty_out(f_empty),
    .level_out()
  );

  // internal requests come only from FIFO state, never self-started.
  // inbound asks when a word waits; outbound asks until full.
  assign int_dma_req_out = chan_enable_in && (mode != EPSD_MODE_OTHER) &&
                           (mode != EPSD_MODE_EXT_HANDSHAKE) &&
                           (transmit_in ? f_wr_ready : f_rd_valid);

  // stall writes on full and reads on empty.
  // stalls suppressed by buffer hang disable.
  assign stall = !buffer_hang_disable_in &&
                 ((ext_wr_in && !transmit_in && f_full) ||
                  (ext_rd_in && transmit_in && f_empty));
  assign ack_out = !(stall && ext_sync_in);
  assign host_wait_ready_out = !(stall && !ext_sync_in);
  assign fifo_full_out = f_full;
  assign fifo_empty_out = f_empty;

  // Outbound read data and inbound memory write data are registered.
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ext_rd_data_reg <= '0;
      int_wr_data_reg <= '0;
      int_wr_strobe_reg <= 1'b0;
    end
    else
    begin
      if (transmit_in && f_rd_ready && f_rd_valid)
      begin
        ext_rd_data_reg <= f_rd_data;
      end
      int_wr_strobe_reg <= !transmit_in && f_rd_ready && f_rd_valid;
      if (!transmit_in && f_rd_ready && f_rd_valid)
      begin
        int_wr_data_reg <= f_rd_data;
      end
    end
  end
  assign ext_rd_data_out = ext_rd_data_reg;
  assign int_wr_data_out = int_wr_data_reg;
  assign int_wr_strobe_out = int_wr_strobe_reg;

  // two-flop synchroniser, then a third flop for edge detection.
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      req_sync_reg <= '1;
      req_prev_reg <= 1'b1;
    end
    else
    begin
      req_sync_reg <= {req_sync_reg[0], req_in_n};
      req_prev_reg <= req_sync_reg[1];
    end
  end

  // falling edge starts an access; the synced high level ends it in GRANT.
  assign req_fall = req_prev_reg && !req_sync_reg[1];

  // blocked is full on an inbound write, empty on an outbound read.
  assign blocked = transmit_in ? f_empty : f_full;
  assign grant_fire = (gstate_reg == EPSD_G_RELEASE);

  // pending counter, saturating at seven, flushed and cleared.
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pend_reg <= `EPSD_REQ_ZERO;
    end
    else if (!chan_enable_in || request_flush_bit_in)
    begin
      pend_reg <= `EPSD_REQ_ZERO;
    end
    else if (hs_active)
    begin
      if (req_fall && !grant_fire && pend_reg != `EPSD_REQ_MAX)
      begin
        pend_reg <= pend_reg + `EPSD_REQ_ONE;
      end
      else if (grant_fire && !req_fall)
      begin
        pend_reg <= pend_reg - `EPSD_REQ_ONE;
      end
    end
  end
  assign pending_count_out = pend_reg;

  // grant sequencer: arbitrate, drive grant, release on request high.
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      gstate_reg <= EPSD_G_IDLE;
    end
    else if (!hs_active || request_flush_bit_in)
    begin
      gstate_reg <= EPSD_G_IDLE;
    end
    else
    begin
      case (gstate_reg)
        EPSD_G_IDLE:
        begin
          if (pend_reg != `EPSD_REQ_ZERO && pipe_s3_reg && !blocked)
          begin
            gstate_reg <= EPSD_G_ARB;
          end
        end
        EPSD_G_ARB:
        begin
          if (blocked)
          begin
            gstate_reg <= EPSD_G_IDLE;
          end
          else if (bus_master_in || bus_won_in)
          begin
            gstate_reg <= EPSD_G_GRANT;
          end
        end
        EPSD_G_GRANT:
        begin
          if (req_sync_reg[1])
          begin
            gstate_reg <= EPSD_G_RELEASE;
          end
        end
        EPSD_G_RELEASE:
        begin
          gstate_reg <= EPSD_G_IDLE;
        end
        default:
        begin
          gstate_reg <= EPSD_G_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pipe_s1_reg <= 1'b0;
      pipe_s2_reg <= 1'b0;
      pipe_s3_reg <= 1'b0;
    end
    else
    begin
      pipe_s1_reg <= hs_active && pend_reg != `EPSD_REQ_ZERO;
      pipe_s2_reg <= pipe_s1_reg && hs_active;
      pipe_s3_reg <= pipe_s2_reg && hs_active;
    end
  end

  // one channel instance serves one request/grant pair.
  // the bus request is withdrawn in the very cycle that the FIFO blocks.
  assign bus_request_out = (gstate_reg == EPSD_G_ARB) && !bus_master_in && !blocked;
  assign grant_out_n = !(gstate_reg == EPSD_G_GRANT || gstate_reg == EPSD_G_RELEASE);
  assign grant_oe_out = hs_active;

  // bank selects idle except in external handshake mode.
  assign bank_selects_out = (chan_enable_in && mode == EPSD_MODE_EXT_HANDSHAKE &&
                             !req_sync_reg[1]) ? `EPSD_BANK_ACTIVE : `EPSD_BANK_IDLE;
  // rely on the outside party and software.
endmodule : epsd_dma

//--- verification/epsd_host.sv
// Outside peripheral that drives the active-low request pin.
// Assumes the bench paces pulses and never leaves more than seven ungranted.
`timescale 1ns/10ps
module epsd_host (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic pulse_in,
  input wire logic hold_in,
  output logic req_n_out
);
  logic [1:0] ph_reg;
  // short pulse
  // A pulse counts through four phases, low for the first two only.
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      ph_reg <= 2'h0;
    else if (pulse_in || ph_reg != 2'h0)
      ph_reg <= ph_reg + 2'h1;
  // idle high
  // The pin rests high unless a pulse or a long hold is under way.
  assign req_n_out = !(hold_in || ph_reg == 2'h1 || ph_reg == 2'h2);
endmodule : epsd_host

//--- verification/epsd_chk.sv
// Checker bound to the DMA channel top module.
// Assumes one clock and the active-low asynchronous reset of the design.
`timescale 1ns/10ps
module epsd_chk (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic chan_enable_in,
  input wire logic self_initiate_in,
  input wire logic req_grant_mode_bit_in,
  input wire logic extern_mode_in,
  input wire logic transmit_in,
  input wire logic buffer_hang_disable_in,
  input wire logic request_flush_bit_in,
  input wire logic ext_wr_in,
  input wire logic ext_rd_in,
  input wire logic ext_sync_in,
  input wire logic int_dma_grant_in,
  input wire logic int_dma_req_out,
  input wire logic int_wr_strobe_out,
  input wire logic ack_out,
  input wire logic host_wait_ready_out,
  input wire logic grant_out_n,
  input wire logic bus_request_out,
  input wire logic [3:0] bank_selects_out,
  input wire logic fifo_full_out,
  input wire logic fifo_empty_out,
  input wire logic [2:0] pending_count_out
);
  logic slave;
  // Slave mode means every mode bit clear on an enabled channel.
  assign slave = chan_enable_in && !self_initiate_in && !req_grant_mode_bit_in && !extern_mode_in;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  chk_write_stall: assert property (
    !transmit_in && fifo_full_out && ext_wr_in && !buffer_hang_disable_in
    |-> (ext_sync_in ? !ack_out : !host_wait_ready_out))
    else $error("write to full buffer not stalled");
  chk_read_stall: assert property (
    transmit_in && fifo_empty_out && ext_rd_in && !buffer_hang_disable_in
    |-> (ext_sync_in ? !ack_out : !host_wait_ready_out))
    else $error("read of empty buffer not stalled");
  chk_hang_off: assert property (
    buffer_hang_disable_in |-> ack_out && host_wait_ready_out)
    else $error("stall applied with hang disabled");
  chk_inb_idle: assert property (
    slave && !transmit_in && fifo_empty_out |-> !int_dma_req_out)
    else $error("inbound request with empty buffer");
  chk_outb_fill: assert property (
    slave && transmit_in |-> int_dma_req_out == !fifo_full_out)
    else $error("outbound request does not track full");
  chk_mem_write: assert property (
    chan_enable_in && !transmit_in && int_dma_req_out && int_dma_grant_in
    |=> int_wr_strobe_out)
    else $error("granted word not written to memory");
  chk_grant_count: assert property (
    $fell(grant_out_n) |-> $past(pending_count_out) != 3'h0)
    else $error("grant without a counted request");
  chk_flush_clear: assert property (
    request_flush_bit_in |=> pending_count_out == 3'h0)
    else $error("flush left requests stored");
  chk_disable_clear: assert property (
    !chan_enable_in |=> pending_count_out == 3'h0)
    else $error("disabled channel kept requests");
  chk_bank_idle: assert property (
    !extern_mode_in |-> bank_selects_out == 4'hf)
    else $error("bank selects active outside external mode");
  chk_block_arb: assert property (
    bus_request_out |-> !(transmit_in ? fifo_empty_out : fifo_full_out))
    else $error("bus arbitration while buffer blocked");
  cover property (!grant_out_n);
  cover property (fifo_full_out && ext_wr_in);
  cover property (pending_count_out == 3'h3);
endmodule : epsd_chk
bind epsd_dma epsd_chk chk (.*);

//--- verification/tb_top.sv
// Self-checking bench for the external-port DMA channel.
// Assumes design, package, host model and checker are compiled first.
`timescale 1ns/10ps
module tb_top;
  typedef struct packed {logic sy; logic hd; logic ak; logic rd;} epsd_row_t;
  logic ref_clk_in, rst_b_in, en, si, rg, ex, tx, hd, fl, bm, bw, gate, wr, rd, sy, pul, hold;
  logic ig, irq, stb, ack, rdy, req_n, gnt_n, goe, bq, full, empty;
  logic [31:0] idat, wdat, odat, rdat;
  logic [3:0] bank;
  logic [2:0] cnt;
  int n_mismatch, num_checks;
  epsd_row_t rows [4] = '{4'h9, 4'h2, 4'hf, 4'h7};
  // Memory side grants a pending internal request whenever the gate is open.
  assign ig = gate & irq;
  epsd_host host (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .pulse_in(pul),
    .hold_in(hold), .req_n_out(req_n));
  epsd_dma dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .chan_enable_in(en),
    .self_initiate_in(si), .req_grant_mode_bit_in(rg), .extern_mode_in(ex),
    .transmit_in(tx), .buffer_hang_disable_in(hd), .request_flush_bit_in(fl),
    .bus_master_in(bm), .bus_won_in(bw), .bus_request_out(bq), .int_dma_req_out(irq),
    .int_dma_grant_in(ig), .int_rd_data_in(idat), .int_wr_data_out(odat),
    .int_wr_strobe_out(stb), .ext_wr_in(wr), .ext_rd_in(rd), .ext_sync_in(sy),
    .ext_wr_data_in(wdat), .ext_rd_data_out(rdat), .ack_out(ack),
    .host_wait_ready_out(rdy), .req_in_n(req_n), .grant_out_n(gnt_n),
    .grant_oe_out(goe), .bank_selects_out(bank), .fifo_full_out(full),
    .fifo_empty_out(empty), .pending_count_out(cnt));
  // Clock at 100 MHz.
  initial
  begin
    ref_clk_in = 0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // Outbound memory words count up on every grant.
  always @(posedge ref_clk_in)
    if (ig && tx)
      idat <= idat + 32'h1;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (e !== g)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic till(ref logic s, input logic v);
    for (int i = 0; i < 30 && s !== v; i++)
    begin
      @(posedge ref_clk_in);
      #1;
    end
  endtask : till
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // Watchdog cuts a hang short.
  initial
  begin
    #100us;
    n_mismatch++;
    conclude();
  end
  // Main sequence: reset, inbound slave, outbound slave, handshake.
  initial
  begin
    {en, si, rg, ex, tx, hd, fl, bm, bw, gate, wr, rd, sy, pul, hold} = '0;
    wdat = '0;
    idat = 32'h100;
    rst_b_in = 0;
    repeat (3) @(posedge ref_clk_in);
    rst_b_in <= 1;
    #1;
    chk("grant", 1, gnt_n);
    chk("count", 0, cnt);
    @(posedge ref_clk_in);
    en <= 1;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge ref_clk_in);
      wr <= 1;
      wdat <= 32'ha0 + i;
    end
    @(posedge ref_clk_in);
    #1;
    chk("full", 1, full);
    chk("int_req", 1, irq);
    foreach (rows[k])
    begin
      @(posedge ref_clk_in);
      {sy, hd} <= {rows[k].sy, rows[k].hd};
      #1;
      chk("ack", rows[k].ak, ack);
      chk("ready", rows[k].rd, rdy);
    end
    @(posedge ref_clk_in);
    {wr, hd, sy, gate} <= 4'h3;
    till(stb, 1);
    chk("mem_data", 32'ha0, odat);
    chk("full", 0, full);
    till(empty, 1);
    chk("int_req", 0, irq);
    @(posedge ref_clk_in);
    {en, gate, tx} <= 3'h1;
    @(posedge ref_clk_in);
    {en, gate} <= 2'h3;
    till(full, 1);
    chk("int_req", 0, irq);
    @(posedge ref_clk_in);
    {gate, rd} <= 2'h1;
    @(posedge ref_clk_in);
    rd <= 0;
    #1;
    chk("rd_data", 32'h100, rdat);
    chk("int_req", 1, irq);
    @(posedge ref_clk_in);
    rd <= 1;
    repeat (5) @(posedge ref_clk_in);
    #1;
    chk("ack", 0, ack);
    @(posedge ref_clk_in);
    gate <= 1;
    till(ack, 1);
    chk("ack", 1, ack);
    @(posedge ref_clk_in);
    {en, tx, rd} <= 3'h0;
    // no external count
    // This channel keeps no external count, so handshake runs to internal memory only.
    rg <= 1;
    @(posedge ref_clk_in);
    en <= 1;
    repeat (3)
    begin
      @(posedge ref_clk_in);
      pul <= 1;
      @(posedge ref_clk_in);
      pul <= 0;
      repeat (3) @(posedge ref_clk_in);
    end
    repeat (8) @(posedge ref_clk_in);
    #1;
    chk("count", 3, cnt);
    chk("bus_req", 1, bq);
    @(posedge ref_clk_in);
    fl <= 1;
    @(posedge ref_clk_in);
    fl <= 0;
    #1;
    chk("count", 0, cnt);
    @(posedge ref_clk_in);
    {bm, pul} <= 2'h3;
    @(posedge ref_clk_in);
    pul <= 0;
    till(gnt_n, 0);
    chk("grant", 0, gnt_n);
    chk("grant_oe", 1, goe);
    chk("banks", 4'hf, bank);
    till(gnt_n, 1);
    chk("count", 0, cnt);
    @(posedge ref_clk_in);
    {ex, hold} <= 2'h3;
    repeat (6) @(posedge ref_clk_in);
    #1;
    chk("banks", 4'he, bank);
    @(posedge ref_clk_in);
    {si, ex} <= 2'h2;
    @(posedge ref_clk_in);
    #1;
    chk("grant_oe", 0, goe);
    chk("grant", 1, gnt_n);
    chk("int_req", 0, irq);
    conclude();
  end
endmodule : tb_top
